// ### design/osid_pkg.sv
/*
 Shared constants and types for the output-stop input detector.
 Assumes a single 200 MHz peripheral clock and a plain register port.
*/
package osid_pkg;

   // Register port shape
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL8 = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_CTRL10 = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h6;

   // Control register field positions
   localparam int MODE_LSB = 0;
   localparam int COUNT_LSB = 4;
   localparam int INV_BIT = 8;

   // Status and mask bit positions
   localparam int FLAG_IN8 = 0;
   localparam int FLAG_IN10 = 1;

   // Reset values
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;

   // Writable mode bits per variant
   localparam logic [3:0] MODE_MASK_LEGACY = 4'h3;
   localparam logic [3:0] MODE_MASK_EXT = 4'hF;

   // Extended mode codes; legacy uses the low four codes 0..3 likewise
   localparam logic [3:0] MODE_EDGE = 4'h0;
   localparam logic [3:0] MODE_DIV8 = 4'h1;
   localparam logic [3:0] MODE_DIV16 = 4'h2;
   localparam logic [3:0] MODE_DIV128 = 4'h3;
   localparam logic [3:0] MODE_DIV1 = 4'h4;
   localparam logic [3:0] MODE_DIV2 = 4'h5;
   localparam logic [3:0] MODE_DIV4 = 4'h6;

   // Prescaler and low-bit masks giving each sample rate
   localparam int PS_W = 7;
   localparam logic [PS_W-1:0] PS_MASK_DIV1 = 7'h00;
   localparam logic [PS_W-1:0] PS_MASK_DIV2 = 7'h01;
   localparam logic [PS_W-1:0] PS_MASK_DIV4 = 7'h03;
   localparam logic [PS_W-1:0] PS_MASK_DIV8 = 7'h07;
   localparam logic [PS_W-1:0] PS_MASK_DIV16 = 7'h0F;
   localparam logic [PS_W-1:0] PS_MASK_DIV128 = 7'h7F;

   // Run counter
   localparam int RUN_W = 5;
   localparam logic [RUN_W-1:0] RUN_LEGACY = 5'h10;
   localparam logic [RUN_W-1:0] RUN_MAX = 5'h1F;

   typedef struct packed {
      logic invert;
      logic [3:0] count;
      logic [3:0] mode;
   } osid_ctrl_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } osid_bus_req_t;

endpackage

// ### design/osid_top.sv
/*
 Input-request detector for two active-low stop request pins (8 and 10),
 with edge or sampled-level detection, sticky flags and a masked interrupt.
 Assumes pins are asynchronous to REF_CLK and software keeps mode codes legal.
*/
//
// Summary of operation
// - Mode field two bits legacy, four extended.
// - Legacy code 00: falling edge on input 8.
// - Legacy sampled input 8: sixteen lows accepted.
// - Extended code 0000: either edge input 8.
// - Extended input 8 rate chosen by mode.
// - Accept after count plus one equal consecutive samples.
// - Four-bit sample count field for input 8.
// - Invert bit flips input 8 before detection.
// - Legacy code 00: falling edge on input 10.
// - Legacy sampled input 10: sixteen lows accepted.
// - Extended code 0000: either edge input 10.
// - Extended input 10 rates for codes 1-5.
// - Code 0110 samples input 10 at div4.
// - Input 10 has own count and invert.
`timescale 1ns/1ps
module osid_top #(
   parameter bit EXTENDED = 1'b1
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic ARST_N,
   // Stop request pins, active low
   input wire logic STOP_REQUEST_INPUT_8_N,
   input wire logic STOP_REQUEST_INPUT_10_N,
   // Register port
   input wire osid_pkg::osid_bus_req_t REG_REQ,
   output logic [osid_pkg::DATA_W-1:0] REG_RDATA,
   // Accepted requests and interrupt
   output logic STOP_REQUEST_8,
   output logic STOP_REQUEST_10,
   output logic IRQ
);
   import osid_pkg::*;

   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [PS_W-1:0] prescale_r;
   osid_ctrl_t ctrl_r [2];
   logic [1:0] status_r;
   logic [1:0] mask_r;
   logic [1:0] accept;
   logic [DATA_W-1:0] rdata_r;
   logic irq_r;
   logic [1:0] clear_bits;

   // Sample strobe for a mode from the shared prescaler
   function automatic logic sample_tick(input logic [3:0] mode, input logic [PS_W-1:0] ps);
      logic [PS_W-1:0] m;
      m = PS_MASK_DIV1;
      unique case (mode)
         MODE_DIV8: m = PS_MASK_DIV8;
         MODE_DIV16: m = PS_MASK_DIV16;
         MODE_DIV128: m = PS_MASK_DIV128;
         MODE_DIV1: m = PS_MASK_DIV1;
         MODE_DIV2: m = PS_MASK_DIV2;
         MODE_DIV4: m = PS_MASK_DIV4;
         default: m = PS_MASK_DIV1;
      endcase
      return (ps & m) == m;
   endfunction

   // Control word as seen on the register port
   function automatic logic [DATA_W-1:0] ctrl_word(input osid_ctrl_t c);
      logic [DATA_W-1:0] w;
      w = '0;
      w[MODE_LSB +: 4] = c.mode;
      w[COUNT_LSB +: 4] = c.count;
      w[INV_BIT] = c.invert;
      return w;
   endfunction

   // Control word as stored; legacy keeps only two mode bits
   function automatic osid_ctrl_t ctrl_store(input logic [DATA_W-1:0] w);
      osid_ctrl_t c;
      c.mode = w[MODE_LSB +: 4] & (EXTENDED ? MODE_MASK_EXT : MODE_MASK_LEGACY);
      c.count = EXTENDED ? w[COUNT_LSB +: 4] : 4'h0;
      c.invert = EXTENDED ? w[INV_BIT] : 1'b0;
      return c;
   endfunction

   // Pin synchronisers, idle high
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync1_r <= 2'h3;
         sync2_r <= 2'h3;
      end else begin
         sync1_r <= {STOP_REQUEST_INPUT_10_N, STOP_REQUEST_INPUT_8_N};
         sync2_r <= sync1_r;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prescale_r <= '0;
      end else begin
         prescale_r <= PS_W'(prescale_r + 1'b1);
      end
   end

   // Per-input detectors
   for (genvar ch = 0; ch < 2; ch++) begin : g_det
      logic level;
      logic edge_prev_r;
      logic samp_r;
      logic [RUN_W-1:0] run_r;
      logic [RUN_W-1:0] run_nxt;
      logic [RUN_W-1:0] target;
      logic tick;
      logic edge_mode;
      logic edge_hit;
      logic level_hit;

      assign level = sync2_r[ch] ^ (EXTENDED & ctrl_r[ch].invert);

      assign edge_mode = (ctrl_r[ch].mode == MODE_EDGE);
      assign tick = !edge_mode && sample_tick(ctrl_r[ch].mode, prescale_r);

      assign target = EXTENDED ? RUN_W'({1'b0, ctrl_r[ch].count} + 5'h01) : RUN_LEGACY;

      always_comb begin
         if (level != samp_r) begin
            run_nxt = 5'h01;
         end else if (run_r == RUN_MAX) begin
            run_nxt = RUN_MAX;
         end else begin
            run_nxt = RUN_W'(run_r + 1'b1);
         end
      end

      always_ff @(posedge REF_CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            edge_prev_r <= 1'b1;
         end else begin
            edge_prev_r <= level;
         end
      end

      // Saturated run at reset so an idle pin stays quiet
      always_ff @(posedge REF_CLK or negedge ARST_N) begin
         if (!ARST_N) begin
            samp_r <= 1'b1;
            run_r <= RUN_MAX;
         end else if (tick) begin
            samp_r <= level;
            run_r <= run_nxt;
         end
      end

      assign edge_hit = edge_mode &&
         (EXTENDED ? (level != edge_prev_r) : (edge_prev_r && !level));

      assign level_hit = tick && (run_nxt == target) && (EXTENDED || !level);

      assign accept[ch] = edge_hit || level_hit;
   end

   // Write-one-to-clear bits of this cycle
   always_comb begin
      clear_bits = 2'h0;
      if (REG_REQ.wr && REG_REQ.addr == ADDR_STATUS) begin
         clear_bits = REG_REQ.wdata[1:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         status_r <= STATUS_RESET;
      end else begin
         status_r <= (status_r & ~clear_bits) | accept;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_r[0] <= ctrl_store(CTRL_RESET);
         ctrl_r[1] <= ctrl_store(CTRL_RESET);
         mask_r <= MASK_RESET;
      end else if (REG_REQ.wr) begin
         unique case (REG_REQ.addr)
            ADDR_CTRL8: ctrl_r[0] <= ctrl_store(REG_REQ.wdata);
            ADDR_CTRL10: ctrl_r[1] <= ctrl_store(REG_REQ.wdata);
            ADDR_MASK: mask_r <= REG_REQ.wdata[1:0];
            default: ;
         endcase
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_r <= '0;
      end else if (REG_REQ.rd) begin
         unique case (REG_REQ.addr)
            ADDR_CTRL8: rdata_r <= ctrl_word(ctrl_r[0]);
            ADDR_CTRL10: rdata_r <= ctrl_word(ctrl_r[1]);
            ADDR_STATUS: rdata_r <= {14'h0000, status_r};
            ADDR_MASK: rdata_r <= {14'h0000, mask_r};
            default: rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_r & mask_r);
      end
   end

   assign REG_RDATA = rdata_r;
   assign STOP_REQUEST_8 = status_r[FLAG_IN8];
   assign STOP_REQUEST_10 = status_r[FLAG_IN10];
   assign IRQ = irq_r;

endmodule

// ### tb/osid_monitor.sv
/* Port checker for the stop request detector, bound into osid_top.
 Assumes the extended variant and the register map of osid_pkg. */
`timescale 1ns/1ps
module osid_monitor (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic ARST_N,
   // Pins and register port
   input wire logic STOP_REQUEST_INPUT_8_N,
   input wire logic STOP_REQUEST_INPUT_10_N,
   input wire osid_pkg::osid_bus_req_t REG_REQ,
   input wire logic [osid_pkg::DATA_W-1:0] REG_RDATA,
   // Results
   input wire logic STOP_REQUEST_8,
   input wire logic STOP_REQUEST_10,
   input wire logic IRQ
);
   import osid_pkg::*;
   logic [8:0] c8_r, c10_r;
   logic [1:0] mask_r;
   logic clr8, clr10;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   assign clr8 = REG_REQ.wr && REG_REQ.addr == ADDR_STATUS && REG_REQ.wdata[0];
   assign clr10 = REG_REQ.wr && REG_REQ.addr == ADDR_STATUS && REG_REQ.wdata[1];
   // Shadow of control and mask
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         c8_r <= 9'h000;
         c10_r <= 9'h000;
         mask_r <= 2'h0;
      end else if (REG_REQ.wr) begin
         if (REG_REQ.addr == ADDR_CTRL8) c8_r <= REG_REQ.wdata[8:0];
         if (REG_REQ.addr == ADDR_CTRL10) c10_r <= REG_REQ.wdata[8:0];
         if (REG_REQ.addr == ADDR_MASK) mask_r <= REG_REQ.wdata[1:0];
      end
   end
   sequence s_low_run8;
      (c8_r == 9'h034 && !STOP_REQUEST_INPUT_8_N && !clr8) [*8];
   endsequence
   property p_run8;
      $fell(STOP_REQUEST_INPUT_8_N) ##0 s_low_run8 |=> STOP_REQUEST_8;
   endproperty
   property p_edge8;
      $changed(STOP_REQUEST_INPUT_8_N) && c8_r[3:0] == MODE_EDGE |-> ##[1:3] STOP_REQUEST_8;
   endproperty
   property p_edge10;
      $changed(STOP_REQUEST_INPUT_10_N) && c10_r[3:0] == MODE_EDGE |-> ##[1:3] STOP_REQUEST_10;
   endproperty
   property p_sticky8;
      STOP_REQUEST_8 && !clr8 |=> STOP_REQUEST_8;
   endproperty
   property p_sticky10;
      STOP_REQUEST_10 && !clr10 |=> STOP_REQUEST_10;
   endproperty
   property p_irq;
      IRQ == |($past({STOP_REQUEST_10, STOP_REQUEST_8}) & $past(mask_r));
   endproperty
   property p_rd_status;
      REG_REQ.rd && REG_REQ.addr == ADDR_STATUS |=>
         REG_RDATA == {14'h0000, $past(STOP_REQUEST_10), $past(STOP_REQUEST_8)};
   endproperty
   property p_rd_idle;
      !REG_REQ.rd |=> REG_RDATA == 16'h0000;
   endproperty
   a_run8: assert property (p_run8) else $error("input 8 low run not accepted");
   a_edge8: assert property (p_edge8) else $error("input 8 edge missed");
   a_edge10: assert property (p_edge10) else $error("input 10 edge missed");
   a_sticky8: assert property (p_sticky8) else $error("flag 8 dropped");
   a_sticky10: assert property (p_sticky10) else $error("flag 10 dropped");
   a_irq: assert property (p_irq) else $error("interrupt level wrong");
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule
bind osid_top osid_monitor u_mon (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
   .STOP_REQUEST_INPUT_8_N(STOP_REQUEST_INPUT_8_N),
   .STOP_REQUEST_INPUT_10_N(STOP_REQUEST_INPUT_10_N), .REG_REQ(REG_REQ),
   .REG_RDATA(REG_RDATA), .STOP_REQUEST_8(STOP_REQUEST_8),
   .STOP_REQUEST_10(STOP_REQUEST_10), .IRQ(IRQ));

// ### tb/osid_pin_src.sv
/* Stop request sources for pins 8 and 10.
 Assumes the bench asks for a low level per pin; idle pins are driven high by this model, one clock after the request. */
`timescale 1ns/1ps
module osid_pin_src (
   // Clock and requests
   input wire logic clk,
   input wire logic [1:0] want_low,
   // Active-low pins
   output logic pin8_n = 1'b1,
   output logic pin10_n = 1'b1
);
   always_ff @(posedge clk) begin
      pin8_n <= !want_low[0];
      pin10_n <= !want_low[1];
   end
endmodule

// ### tb/osid_top_test.sv
/* Self-checking bench for the stop request detector.
 Assumes the extended build, a 200 MHz clock and the pin source model. */
`timescale 1ns/1ps
module osid_top_test;
   import osid_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0, rd_d = 1'b0;
   logic [1:0] want_low = 2'h0;
   logic pin8_n, pin10_n, irq, flag8, flag10;
   int m, ch;
   osid_bus_req_t req = '0;
   logic [DATA_W-1:0] rdata, d;
   logic [DATA_W-1:0] exp_q[$];
   int num_errors = 0, comparisons = 0, seed = 55335;
   int divs[7] = '{0, 8, 16, 128, 1, 2, 4};
   always #2.5 ref_clk = ~ref_clk;
   osid_pin_src u_src (.clk(ref_clk), .want_low(want_low), .pin8_n(pin8_n), .pin10_n(pin10_n));
   osid_top u_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .STOP_REQUEST_INPUT_8_N(pin8_n),
      .STOP_REQUEST_INPUT_10_N(pin10_n), .REG_REQ(req), .REG_RDATA(rdata),
      .STOP_REQUEST_8(flag8), .STOP_REQUEST_10(flag10), .IRQ(irq));
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
      comparisons++;
      if (got !== want) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      req <= '{a, v, 1'b1, 1'b0};
      @(posedge ref_clk);
      req <= '0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge ref_clk);
      req <= '0;
      @(posedge ref_clk);
   endtask
   task automatic finish_test;
      if (num_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      if (rd_d) check(rdata, exp_q.pop_front());
      rd_d <= req.rd;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      for (int a = 0; a < 10; a += 2) rd(ADDR_W'(a), 16'h0000);
      for (int i = 0; i < 14; i++) begin
         d = (16'($random(seed)) & 16'h01F0) | 16'(i % 7);
         wr(i[0] ? ADDR_CTRL10 : ADDR_CTRL8, d);
         rd(i[0] ? ADDR_CTRL10 : ADDR_CTRL8, d);
      end
      wr(ADDR_CTRL8, 16'h0000);
      wr(ADDR_CTRL10, 16'h0100);
      wr(ADDR_MASK, 16'h0001);
      wr(ADDR_STATUS, 16'h0003);
      for (int k = 0; k < 4; k++) begin
         want_low[k[1]] <= !k[0];
         repeat (6) @(posedge ref_clk);
         rd(ADDR_STATUS, k[1] ? 16'h0002 : 16'h0001);
         check({15'h0000, irq}, {15'h0000, !k[1]});
         check({14'h0000, flag10, flag8}, k[1] ? 16'h0002 : 16'h0001);
         wr(ADDR_STATUS, 16'h0003);
      end
      // Both inputs through every rate, second pass inverted
      for (int j = 0; j < 12; j++) begin
         m = j % 6 + 1;
         ch = m % 2 ^ (j / 6);
         wr(ch[0] ? ADDR_CTRL10 : ADDR_CTRL8,
            16'h0030 | 16'(m) | (j < 6 ? 16'h0000 : 16'h0100));
         repeat (600) @(posedge ref_clk);
         wr(ADDR_STATUS, 16'h0003);
         want_low[ch[0]] <= 1'b1;
         repeat (3 * divs[m] - 1) @(posedge ref_clk);
         rd(ADDR_STATUS, 16'h0000);
         repeat (divs[m] + 8) @(posedge ref_clk);
         rd(ADDR_STATUS, ch[0] ? 16'h0002 : 16'h0001);
         want_low <= 2'h0;
      end
      repeat (3) @(posedge ref_clk);
      finish_test();
   end
endmodule
